// ---- rtl/ppc_checker.sv ----
// page protection checker top: verdict logic, status and apb access
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/100ps
module ppc_checker #(
    parameter int LEVELS   = ppc_pkg::LEVELS,
    parameter int DP_LEVEL = ppc_pkg::DP_LEVEL
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [ppc_pkg::AW-1:0]  paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    req_valid,
    input  wire logic [1:0]              req_kind,
    input  wire logic [1:0]              req_priv,
    input  wire logic [LEVELS-1:0]       walk_used,
    input  wire logic [LEVELS-1:0]       walk_user,
    input  wire logic [LEVELS-1:0]       walk_write,
    input  wire logic [LEVELS-1:0]       walk_xd,
    output logic                         resp_valid,
    output logic                         resp_allow,
    output logic                         page_fault,
    output logic                         mem_go,
    output logic [ppc_pkg::CAUSE_W-1:0]  fault_cause
);
    import ppc_pkg::*;

    logic               wp;
    logic               xde;
    logic               long_form;
    logic               epp;
    logic               guard;
    logic               eff_user;
    logic               eff_rw_all;
    logic               eff_no_exec;
    logic               pae32_form;
    logic               is_user_priv;
    logic               is_write;
    logic               is_fetch;
    logic               eff_writable;
    logic [CAUSE_W-1:0] cause;
    logic               fault_any;
    logic [31:0]        fault_cnt_reg;
    logic [31:0]        req_cnt_reg;
    logic [CAUSE_W-1:0] cause_reg;

    // ----------------------------------------------------------------
    // register access
    // ----------------------------------------------------------------
    ppc_apb_regs u_regs (
        .pclk       (pclk),
        .presetn    (presetn),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .wp_reg     (wp),
        .xde_reg    (xde),
        .long_reg   (long_form),
        .epp_reg    (epp),
        .guard_reg  (guard),
        .fault_cnt  (fault_cnt_reg),
        .req_cnt    (req_cnt_reg),
        .last_cause (cause_reg)
    );

    // ----------------------------------------------------------------
    // walk flag folding
    // ----------------------------------------------------------------
    assign pae32_form = epp & ~long_form;

    ppc_walk_merge #(
        .LEVELS   (LEVELS),
        .DP_LEVEL (DP_LEVEL)
    ) u_merge (
        .walk_used   (walk_used),
        .walk_user   (walk_user),
        .walk_write  (walk_write),
        .walk_xd     (walk_xd),
        .pae32_form  (pae32_form),
        .eff_user    (eff_user),
        .eff_rw_all  (eff_rw_all),
        .eff_no_exec (eff_no_exec)
    );

    // ----------------------------------------------------------------
    // verdict
    // ----------------------------------------------------------------
    assign is_user_priv = (req_priv == USER_PRIV);
    assign is_write     = (req_kind == PPC_WRITE);
    assign is_fetch     = (req_kind == PPC_FETCH);

    // supervisor without write protect overrides read-only marks
    assign eff_writable = eff_rw_all | (~is_user_priv & ~wp);

    always_comb begin
        cause = '0;
        // supervisor page seen from user privilege
        cause[C_PRIV] = is_user_priv & ~eff_user;
        // user writers always blocked, supervisors only under wp
        cause[C_WRITE] = is_write & ~eff_writable;
        // exec disable needs both the enable and extended paging
        cause[C_XD] = is_fetch & eff_no_exec & xde & epp;
        cause[C_GUARD] = is_fetch & guard & ~is_user_priv
                         & eff_user;
    end

    // rsvd kind is treated as a plain read: no extra check applies
    assign fault_any   = |cause;
    assign resp_valid  = req_valid;
    assign page_fault  = req_valid & fault_any;
    assign resp_allow  = req_valid & ~fault_any;
    // the pipeline only issues the access on mem_go
    assign mem_go      = req_valid & ~fault_any;
    assign fault_cause = cause_reg;

    // ----------------------------------------------------------------
    // status
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_reg <= '0;
        end else if (page_fault) begin
            cause_reg <= cause;
        end
    end

    // counters wrap; software takes differences
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_cnt_reg <= CNT_RST;
        end else if (page_fault) begin
            fault_cnt_reg <= fault_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_cnt_reg <= CNT_RST;
        end else if (req_valid) begin
            req_cnt_reg <= req_cnt_reg + 32'h1;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    logic any_super_chk;
    logic any_ro_chk;
    assign any_super_chk = |(walk_used & ~walk_user);
    assign any_ro_chk    = |(walk_used & ~walk_write);

    a_user_super: assert property (
        @(posedge pclk) disable iff (!presetn)
        req_valid && req_priv == 2'h3 && any_super_chk |-> page_fault && !mem_go)
        else $error("user access to supervisor page not faulted");

    a_sup_read_ok: assert property (
        @(posedge pclk) disable iff (!presetn)
        req_valid && req_priv != 2'h3 && req_kind == PPC_READ |-> resp_allow)
        else $error("supervisor read refused");

    a_user_ro_wr: assert property (
        @(posedge pclk) disable iff (!presetn)
        req_valid && req_priv == 2'h3 && req_kind == PPC_WRITE && any_ro_chk
        |-> page_fault)
        else $error("user write to read-only page allowed");

    a_sup_wr_nowp: assert property (
        @(posedge pclk) disable iff (!presetn)
        req_valid && req_priv != 2'h3 && req_kind == PPC_WRITE && !wp
        |-> !cause[C_WRITE])
        else $error("supervisor write refused with protect off");

    a_wp_ro_wr: assert property (
        @(posedge pclk) disable iff (!presetn)
        req_valid && req_kind == PPC_WRITE && wp && any_ro_chk |-> page_fault)
        else $error("read-only write allowed under protect");

    a_xd_fetch: assert property (
        @(posedge pclk) disable iff (!presetn)
        req_valid && req_kind == PPC_FETCH && xde && epp && long_form
        && |(walk_used & walk_xd) |-> page_fault)
        else $error("fetch from no-execute page allowed");

    a_xd_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        req_valid && (!xde || !epp) |-> !cause[C_XD])
        else $error("exec fault raised while check disabled");

    a_dp_ignored: assert property (
        @(posedge pclk) disable iff (!presetn)
        req_valid && req_kind == PPC_FETCH && epp && !long_form
        && walk_xd == (LEVELS'(1) << DP_LEVEL) |-> !cause[C_XD])
        else $error("dir-pointer exec bit honoured in 32-bit form");

    a_guard_fetch: assert property (
        @(posedge pclk) disable iff (!presetn)
        req_valid && req_kind == PPC_FETCH && guard && req_priv != 2'h3
        && !any_super_chk |-> page_fault)
        else $error("supervisor fetch from user page allowed");

    a_guard_load: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && penable && pwrite && paddr == CTRL4_OFF
        |=> guard == $past(pwdata[GUARD_BIT]))
        else $error("fetch guard not loaded from bit 20");

    a_block_access: assert property (
        @(posedge pclk) disable iff (!presetn)
        req_valid |-> (page_fault ^ mem_go) && (resp_allow == mem_go))
        else $error("verdict and access gate disagree");

    a_fault_count: assert property (
        @(posedge pclk) disable iff (!presetn)
        page_fault |=> fault_cnt_reg == $past(fault_cnt_reg) + 32'h1
        && cause_reg != '0)
        else $error("fault not recorded");

    c_user_fault: cover property (
        @(posedge pclk) disable iff (!presetn)
        page_fault && cause[C_PRIV]);

    c_wp_fault: cover property (
        @(posedge pclk) disable iff (!presetn)
        page_fault && cause[C_WRITE] && req_priv != 2'h3);

    c_xd_fault: cover property (
        @(posedge pclk) disable iff (!presetn)
        page_fault && cause[C_XD]);

    c_guard_then_ok: cover property (
        @(posedge pclk) disable iff (!presetn)
        page_fault && cause[C_GUARD] ##1 resp_allow);
endmodule

// ---- common/ppc_pkg.sv ----
// constants and shared types of the page protection checker
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package ppc_pkg;
    localparam int          LEVELS       = 4;
    localparam int          DP_LEVEL     = 2;
    localparam logic [1:0]  USER_PRIV    = 2'h3;
    localparam int          AW           = 8;
    localparam logic [7:0]  CTRL0_OFF    = 8'h00;
    localparam logic [7:0]  EXTF_OFF     = 8'h04;
    localparam logic [7:0]  CTRL4_OFF    = 8'h0c;
    localparam logic [7:0]  FCNT_OFF     = 8'h10;
    localparam logic [7:0]  CAUSE_OFF    = 8'h14;
    localparam logic [7:0]  RCNT_OFF     = 8'h18;
    localparam int          WP_BIT       = 16;
    localparam int          LONG_BIT     = 10;
    localparam int          XDE_BIT      = 11;
    localparam int          EPP_BIT      = 5;
    localparam int          GUARD_BIT    = 20;
    localparam logic        CTRL_RST     = 1'b0;
    localparam logic [31:0] CNT_RST      = 32'h0;
    localparam int          CAUSE_W      = 4;
    localparam int          C_PRIV       = 0;
    localparam int          C_WRITE      = 1;
    localparam int          C_XD         = 2;
    localparam int          C_GUARD      = 3;
    typedef enum logic [1:0] {
        PPC_READ,
        PPC_WRITE,
        PPC_FETCH,
        PPC_RSVD
    } ppc_kind_e;
endpackage

// ---- rtl/ppc_walk_merge.sv ----
// folds the per-level walk flags into effective page attributes
`timescale 1ns/100ps
module ppc_walk_merge #(
    parameter int LEVELS   = ppc_pkg::LEVELS,
    parameter int DP_LEVEL = ppc_pkg::DP_LEVEL
) (
    input  wire logic [LEVELS-1:0] walk_used,
    input  wire logic [LEVELS-1:0] walk_user,
    input  wire logic [LEVELS-1:0] walk_write,
    input  wire logic [LEVELS-1:0] walk_xd,
    input  wire logic              pae32_form,
    output logic                   eff_user,
    output logic                   eff_rw_all,
    output logic                   eff_no_exec
);
    import ppc_pkg::*;
    logic [LEVELS-1:0] super_hit;
    logic [LEVELS-1:0] ro_hit;
    logic [LEVELS-1:0] xd_hit;

    // ----------------------------------------------------------------
    // per-level contributions
    // ----------------------------------------------------------------
    for (genvar i = 0; i < LEVELS; i++) begin : g_lvl
        assign super_hit[i] = walk_used[i] & ~walk_user[i];
        assign ro_hit[i]    = walk_used[i] & ~walk_write[i];
        // dir-pointer entry has no exec-disable bit in 32-bit form
        if (i == DP_LEVEL) begin : g_dp
            assign xd_hit[i] = walk_used[i] & walk_xd[i] & ~pae32_form;
        end else begin : g_nd
            assign xd_hit[i] = walk_used[i] & walk_xd[i];
        end
    end

    assign eff_user    = ~(|super_hit);
    assign eff_rw_all  = ~(|ro_hit);
    assign eff_no_exec = |xd_hit;
endmodule

// ---- rtl/ppc_apb_regs.sv ----
// apb slave holding the control bits and exposing checker status
`timescale 1ns/100ps
module ppc_apb_regs (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ppc_pkg::AW-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic                       wp_reg,
    output logic                       xde_reg,
    output logic                       long_reg,
    output logic                       epp_reg,
    output logic                       guard_reg,
    input  wire logic [31:0]           fault_cnt,
    input  wire logic [31:0]           req_cnt,
    input  wire logic [ppc_pkg::CAUSE_W-1:0] last_cause
);
    import ppc_pkg::*;
    logic        hit;
    logic [31:0] rd_next;
    logic        wr_go;

    assign pready = 1'b1;
    assign wr_go  = psel & penable & pwrite;

    always_comb begin
        hit     = 1'b1;
        rd_next = 32'h0;
        case (paddr)
            CTRL0_OFF: rd_next[WP_BIT] = wp_reg;
            EXTF_OFF: begin
                rd_next[XDE_BIT]  = xde_reg;
                rd_next[LONG_BIT] = long_reg;
            end
            CTRL4_OFF: begin
                rd_next[GUARD_BIT] = guard_reg;
                rd_next[EPP_BIT]   = epp_reg;
            end
            FCNT_OFF:  rd_next = fault_cnt;
            CAUSE_OFF: rd_next[CAUSE_W-1:0] = last_cause;
            RCNT_OFF:  rd_next = req_cnt;
            default:   hit = 1'b0;
        endcase
    end

    // read data is latched in the setup cycle so it leaves a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h0 : rd_next;
        end
    end

    assign pslverr = psel & penable & ~hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_reg    <= CTRL_RST;
            xde_reg   <= CTRL_RST;
            long_reg  <= CTRL_RST;
            epp_reg   <= CTRL_RST;
            guard_reg <= CTRL_RST;
        end else if (wr_go) begin
            if (paddr == CTRL0_OFF) begin
                wp_reg <= pwdata[WP_BIT];
            end
            if (paddr == EXTF_OFF) begin
                xde_reg  <= pwdata[XDE_BIT];
                long_reg <= pwdata[LONG_BIT];
            end
            if (paddr == CTRL4_OFF) begin
                guard_reg <= pwdata[GUARD_BIT];
                epp_reg   <= pwdata[EPP_BIT];
            end
        end
    end
endmodule

// ---- tb/ppc_pipe_model.sv ----
// pipeline and table walker model that presents one check request per cycle
`timescale 1ns/100ps
module ppc_pipe_model (
    input  wire logic       pclk,
    output logic            req_valid,
    output logic [1:0]      req_kind,
    output logic [1:0]      req_priv,
    output logic [3:0]      walk_used,
    output logic [3:0]      walk_user,
    output logic [3:0]      walk_write,
    output logic [3:0]      walk_xd
);
    initial begin
        req_valid  = 1'b0;
        req_kind   = 2'h0;
        req_priv   = 2'h0;
        walk_used  = 4'h0;
        walk_user  = 4'h0;
        walk_write = 4'h0;
        walk_xd    = 4'h0;
    end

    // kind, privilege and the flags of every level move together
    task automatic issue(input logic [1:0] k, input logic [1:0] p, input logic [15:0] w);
        @(posedge pclk);
        req_valid <= 1'b1;
        req_kind  <= k;
        req_priv  <= p;
        {walk_used, walk_user, walk_write, walk_xd} <= w;
    endtask

    // released lines other than walk_used flip so that stale flags never look valid
    task automatic idle();
        @(posedge pclk);
        req_valid  <= 1'b0;
        req_kind   <= ~req_kind;
        req_priv   <= ~req_priv;
        walk_user  <= ~walk_user;
        walk_write <= ~walk_write;
        walk_xd    <= ~walk_xd;
    endtask
endmodule

// ---- tb/page_protection_check_test.sv ----
// self-checking bench of the page protection checker
`timescale 1ns/100ps
module page_protection_check_test;
    import ppc_pkg::*;
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [AW-1:0]     paddr = '0;
    logic [31:0]       pwdata = 32'h0;
    logic [31:0]       prdata;
    logic              pready, pslverr, req_valid, resp_valid, resp_allow, page_fault, mem_go;
    logic [1:0]        req_kind, req_priv;
    logic [3:0]        walk_used, walk_user, walk_write, walk_xd;
    logic [CAUSE_W-1:0] fault_cause;
    logic [31:0]       rd;
    logic              er;
    int                err_total = 0;
    int                checks = 0;

    always #25 pclk = ~pclk;

    ppc_checker dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .req_valid(req_valid), .req_kind(req_kind), .req_priv(req_priv),
        .walk_used(walk_used), .walk_user(walk_user), .walk_write(walk_write),
        .walk_xd(walk_xd), .resp_valid(resp_valid), .resp_allow(resp_allow),
        .page_fault(page_fault), .mem_go(mem_go), .fault_cause(fault_cause));
    ppc_pipe_model pipe (.pclk(pclk), .req_valid(req_valid), .req_kind(req_kind),
        .req_priv(req_priv), .walk_used(walk_used), .walk_user(walk_user),
        .walk_write(walk_write), .walk_xd(walk_xd));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // no wait limit here: only the watchdog ends a stalled slave
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // c: wp, exec enable, long form, fetch guard, extended paging
    task automatic set_ctrl(input logic [4:0] c);
        apb(1'b1, CTRL0_OFF, 32'(c[0]) << WP_BIT, rd, er);
        apb(1'b1, EXTF_OFF, (32'(c[1]) << XDE_BIT) | (32'(c[2]) << LONG_BIT), rd, er);
        apb(1'b1, CTRL4_OFF, (32'(c[3]) << GUARD_BIT) | (32'(c[4]) << EPP_BIT), rd, er);
    endtask

    function automatic logic exp_fault(input logic [1:0] k, input logic [1:0] p,
                                       input logic [15:0] w, input logic [4:0] c);
        logic [3:0] u, us, wr, xd;
        logic       f;
        {u, us, wr, xd} = w;
        if (c[4] && !c[2]) xd[DP_LEVEL] = 1'b0;                            // 32-bit form
        f = (p == USER_PRIV) && |(u & ~us);
        f |= (k == PPC_WRITE) && |(u & ~wr) && (p == USER_PRIV || c[0]);
        f |= (k == PPC_FETCH) && c[1] && c[4] && |(u & xd);
        f |= (k == PPC_FETCH) && c[3] && p != USER_PRIV && &(~u | us);
        return f;
    endfunction

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        logic [7:0]  offs [6] = '{CTRL0_OFF, EXTF_OFF, CTRL4_OFF, FCNT_OFF, CAUSE_OFF, RCNT_OFF};
        logic [31:0] msk [3] = '{32'h0001_0000, 32'h0000_0c00, 32'h0010_0020};
        foreach (offs[i]) begin
            apb(1'b0, offs[i], 32'h0, rd, er);
            check(rd, CNT_RST);
            check({31'h0, er}, 32'h0);
        end
        foreach (msk[i]) begin
            apb(1'b1, offs[i], 32'hffff_ffff, rd, er);
            apb(1'b0, offs[i], 32'h0, rd, er);
            check(rd, msk[i]);
        end
        apb(1'b1, FCNT_OFF, 32'hffff_ffff, rd, er);
        apb(1'b0, FCNT_OFF, 32'h0, rd, er);
        check(rd, 32'h0);
        apb(1'b0, 8'h08, 32'h0, rd, er);
        check({rd[30:0], er}, 32'h1);
        apb(1'b1, 8'h1c, 32'h5, rd, er);
        check({31'h0, er}, 32'h1);
        set_ctrl(5'h00);
    endtask

    // one single-cause fault of each kind, then an allowed request
    task automatic t_status();
        logic [4:0]  c [5] = '{5'h00, 5'h00, 5'h16, 5'h08, 5'h00};
        logic [1:0]  k [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
        logic [1:0]  p [5] = '{2'h3, 2'h3, 2'h3, 2'h0, 2'h3};
        logic [15:0] w [5] = '{16'hf7f0, 16'hffe0, 16'hfff1, 16'hfff0, 16'hfff0};
        logic [3:0]  cs [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h8};
        foreach (c[i]) begin
            set_ctrl(c[i]);
            pipe.issue(k[i], p[i], w[i]);
            #10;
            check({page_fault, mem_go}, {30'h0, i < 4, i == 4});
            pipe.idle();
            #10;
            check({fault_cause, resp_valid, mem_go}, {cs[i], 2'b00});
        end
        apb(1'b0, FCNT_OFF, 32'h0, rd, er);
        check(rd, 32'h4);
        apb(1'b0, RCNT_OFF, 32'h0, rd, er);
        check(rd, 32'h5);
        apb(1'b0, CAUSE_OFF, 32'h0, rd, er);
        check(rd, 32'h8);
    endtask

    // every control setting against every kind and privilege, over seven walk shapes
    task automatic t_sweep();
        logic [15:0] pat [7] = '{16'hfff0, 16'hf7f0, 16'hffd0, 16'hfff4, 16'hfff1,
                                 16'h333c, 16'hf00f};
        logic        e;
        for (int c = 0; c < 32; c++) begin
            set_ctrl(5'(c));
            for (int k = 0; k < 4; k++) begin
                for (int p = 0; p < 4; p++) begin
                    foreach (pat[i]) begin
                        pipe.issue(2'(k), 2'(p), pat[i]);
                        e = exp_fault(2'(k), 2'(p), pat[i], 5'(c));
                        #10;
                        check({resp_valid, resp_allow, page_fault, mem_go},
                              {1'b1, ~e, e, ~e});
                    end
                end
            end
            pipe.idle();
        end
    endtask

    // reset in mid-run clears controls, last cause and fault counter
    task automatic t_reset();
        set_ctrl(5'h1f);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check({28'h0, fault_cause}, 32'h0);
        apb(1'b0, CTRL0_OFF, 32'h0, rd, er);
        check(rd, 32'h0);
        apb(1'b0, EXTF_OFF, 32'h0, rd, er);
        check(rd, 32'h0);
        apb(1'b0, CTRL4_OFF, 32'h0, rd, er);
        check(rd, 32'h0);
        apb(1'b0, FCNT_OFF, 32'h0, rd, er);
        check(rd, 32'h0);
    endtask

    task automatic give_verdict();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #2_000_000;
        err_total++;
        give_verdict();
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_status();
        t_sweep();
        t_reset();
        give_verdict();
    end
endmodule
